// >>> logic/tone_gen_pkg.sv
// Constants and register map of the melody and alarm tone generator.
//------------------------------------------------------------------------------
// Behaviour
// - Output-select bit 1 routes melody to the tone pin; 0 routes alarm.
// - Divisor is 12 bits: low register bits, high register bits 3..0 on top.
// - Melody frequency is 32768 divided by two times divisor plus four.
// - High register bit 7 at 1 runs the melody counter; 0 stops and clears.
// - Counter control field: 00 hold, 01 restart, 10 clear, 11 clear and start.
// - Upper bit of the counter control field always reads back as zero.
// - Pattern register is one-hot; zero gives constant low; others are forbidden.
// - Alarm waveforms are a 4096 Hz carrier gated by the chosen pattern.
// - Pattern two gives 31.25 ms bursts, eight per second.
// - Inversion bit at 1 inverts the alarm waveform before the pin.
// - Free-run counter raises periodic events at 1, 2, 64, 512 and 8192 Hz.
// - Enable bits 4..0 each gate one periodic event; bit 5 written as zero.
// - The shared free-run counter is 15 bits wide.
//------------------------------------------------------------------------------
package tone_gen_pkg;

  //----------------------------------------------------------------------------
  // Register map
  //----------------------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 8;
  localparam logic [11:0] ADDR_PATTERN    = 12'h330;
  localparam logic [11:0] ADDR_CONTROL    = 12'h331;
  localparam logic [11:0] ADDR_DIV_LOW    = 12'h332;
  localparam logic [11:0] ADDR_DIV_HIGH   = 12'h333;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h334;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h335;
  localparam logic [7:0]  REG_RESET       = 8'h00;

  //----------------------------------------------------------------------------
  // Field layout
  //----------------------------------------------------------------------------
  localparam int          CTRL_FC_HI      = 7;
  localparam int          CTRL_FC_LO      = 6;
  localparam int          CTRL_INVERT     = 5;
  localparam int          CTRL_SELECT     = 0;
  localparam logic [7:0]  CTRL_SPARE_MASK = 8'h1e;
  localparam int          HIGH_RUN        = 7;
  localparam logic [1:0]  FC_HOLD         = 2'h0;
  localparam logic [1:0]  FC_RESTART      = 2'h1;
  localparam logic [1:0]  FC_CLEAR        = 2'h2;
  localparam logic [1:0]  FC_CLEAR_START  = 2'h3;

  //----------------------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------------------
  localparam int           DIV_W        = 12;
  localparam int           FREE_W       = 15;
  localparam int           IRQ_N        = 5;
  localparam int           CARRIER_TAP  = 2;
  localparam logic [12:0]  MEL_HALF_ADD = 13'h0001;
  localparam logic [14:0]  FREE_ONE     = 15'h0001;
  // Wrap masks of the free-run counter by event bit; bit 0 is the 1 Hz event.
  // The list runs from bit 4 down: 8192, 512, 64, 2 and 1 Hz.
  localparam logic [4:0][14:0] IRQ_WRAP_MASK = {15'h0003, 15'h003f, 15'h01ff,
                                                15'h3fff, 15'h7fff};

endpackage

// >>> logic/melody_alarm_tone_generator.sv
// Melody and alarm tone generator with periodic interrupts and byte registers.
`timescale 1ns/1ps

module melody_alarm_tone_generator
  import tone_gen_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              lowspeed_clk,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  output logic                   tone_out_pin,
  output logic                   irq
);

  //----------------------------------------------------------------------------
  // Low-speed clock sampling
  //----------------------------------------------------------------------------
  // The low-speed clock is far slower than sys_clk, so it is sampled as a level
  // and each rising edge becomes a one-cycle tick.
  logic ls_meta_r;
  logic ls_sync_r;
  logic ls_prev_r;
  logic tick;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ls_meta_r <= 1'b0;
      ls_sync_r <= 1'b0;
      ls_prev_r <= 1'b0;
    end else begin
      ls_meta_r <= lowspeed_clk;
      ls_sync_r <= ls_meta_r;
      ls_prev_r <= ls_sync_r;
    end
  end

  assign tick = ls_sync_r & ~ls_prev_r;

  //----------------------------------------------------------------------------
  // Register file
  //----------------------------------------------------------------------------
  logic [7:0]       pattern_r,  pattern_nxt;
  logic             inv_r,      inv_nxt;
  logic             select_r,   select_nxt;
  logic [3:0]       spare_r,    spare_nxt;
  logic [7:0]       div_low_r,  div_low_nxt;
  logic [3:0]       div_high_r, div_high_nxt;
  logic             mel_run_r,  mel_run_nxt;
  logic [4:0]       irq_en_r,   irq_en_nxt;
  logic [4:0]       status_r,   status_nxt;
  logic [7:0]       rdata_r,    rdata_nxt;
  logic [IRQ_N-1:0] irq_event;
  logic             free_run_r;
  logic [DIV_W-1:0] divisor;
  logic             wr_pattern;
  logic             wr_control;
  logic             wr_div_low;
  logic             wr_div_high;
  logic             wr_irq_en;
  logic             wr_status;

  assign wr_pattern  = wr_en && (addr == ADDR_PATTERN);
  assign wr_control  = wr_en && (addr == ADDR_CONTROL);
  assign wr_div_low  = wr_en && (addr == ADDR_DIV_LOW);
  assign wr_div_high = wr_en && (addr == ADDR_DIV_HIGH);
  assign wr_irq_en   = wr_en && (addr == ADDR_IRQ_ENABLE);
  assign wr_status   = wr_en && (addr == ADDR_IRQ_STATUS);
  assign divisor     = {div_high_r, div_low_r};

  always_comb begin
    pattern_nxt  = pattern_r;
    inv_nxt      = inv_r;
    select_nxt   = select_r;
    spare_nxt    = spare_r;
    div_low_nxt  = div_low_r;
    div_high_nxt = div_high_r;
    mel_run_nxt  = mel_run_r;
    irq_en_nxt   = irq_en_r;
    rdata_nxt    = REG_RESET;
    if (wr_pattern) begin
      pattern_nxt = wdata;
    end
    if (wr_control) begin
      inv_nxt    = wdata[CTRL_INVERT];
      select_nxt = wdata[CTRL_SELECT];
      spare_nxt  = wdata[4:1];
    end
    if (wr_div_low) begin
      div_low_nxt = wdata;
    end
    if (wr_div_high) begin
      div_high_nxt = wdata[3:0];
      mel_run_nxt  = wdata[HIGH_RUN];
    end
    if (wr_irq_en) begin
      irq_en_nxt = wdata[4:0];
    end
    // A new event wins over a write-one-to-clear in the same cycle.
    status_nxt = (status_r & ~(wr_status ? wdata[4:0] : 5'h00)) | irq_event;
    if (rd_en) begin
      case (addr)
        ADDR_PATTERN:    rdata_nxt = pattern_r;
        // Upper field bit reads zero; the lower one shows whether the counter runs.
        ADDR_CONTROL:    rdata_nxt = {1'b0, free_run_r, inv_r, spare_r, select_r};
        ADDR_DIV_LOW:    rdata_nxt = div_low_r;
        ADDR_DIV_HIGH:   rdata_nxt = {mel_run_r, 3'h0, div_high_r};
        ADDR_IRQ_ENABLE: rdata_nxt = {3'h0, irq_en_r};
        ADDR_IRQ_STATUS: rdata_nxt = {3'h0, status_r};
        default:         rdata_nxt = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pattern_r  <= REG_RESET;
      inv_r      <= 1'b0;
      select_r   <= 1'b0;
      spare_r    <= 4'h0;
      div_low_r  <= REG_RESET;
      div_high_r <= 4'h0;
      mel_run_r  <= 1'b0;
      irq_en_r   <= 5'h00;
      status_r   <= 5'h00;
      rdata_r    <= REG_RESET;
    end else begin
      pattern_r  <= pattern_nxt;
      inv_r      <= inv_nxt;
      select_r   <= select_nxt;
      spare_r    <= spare_nxt;
      div_low_r  <= div_low_nxt;
      div_high_r <= div_high_nxt;
      mel_run_r  <= mel_run_nxt;
      irq_en_r   <= irq_en_nxt;
      status_r   <= status_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign irq   = |(status_r & irq_en_r);

  //----------------------------------------------------------------------------
  // Melody counter
  //----------------------------------------------------------------------------
  // Half a period is divisor plus two ticks. A zero divisor still gives a tone,
  // just outside the range software may use.
  logic [12:0] mel_cnt_r,  mel_cnt_nxt;
  logic        mel_wave_r, mel_wave_nxt;
  logic [12:0] mel_last;

  assign mel_last = {1'b0, divisor} + MEL_HALF_ADD;

  always_comb begin
    mel_cnt_nxt  = mel_cnt_r;
    mel_wave_nxt = mel_wave_r;
    if (!mel_run_r) begin
      mel_cnt_nxt  = 13'h0000;
      mel_wave_nxt = 1'b0;
    end else if (tick) begin
      if (mel_cnt_r >= mel_last) begin
        mel_cnt_nxt  = 13'h0000;
        mel_wave_nxt = ~mel_wave_r;
      end else begin
        mel_cnt_nxt = mel_cnt_r + MEL_HALF_ADD;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mel_cnt_r  <= 13'h0000;
      mel_wave_r <= 1'b0;
    end else begin
      mel_cnt_r  <= mel_cnt_nxt;
      mel_wave_r <= mel_wave_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // Free-run counter
  //----------------------------------------------------------------------------
  logic [FREE_W-1:0] free_cnt_r, free_cnt_nxt;
  logic              free_run_nxt;

  always_comb begin
    free_cnt_nxt = free_cnt_r;
    free_run_nxt = free_run_r;
    if (free_run_r && tick) begin
      free_cnt_nxt = free_cnt_r + FREE_ONE;
    end
    if (wr_control) begin
      case (wdata[CTRL_FC_HI:CTRL_FC_LO])
        FC_HOLD: begin
          free_run_nxt = 1'b0;
        end
        FC_RESTART: begin
          free_run_nxt = 1'b1;
        end
        FC_CLEAR: begin
          free_cnt_nxt = '0;
          free_run_nxt = 1'b0;
        end
        FC_CLEAR_START: begin
          free_cnt_nxt = '0;
          free_run_nxt = 1'b1;
        end
        default: begin
          free_run_nxt = free_run_r;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      free_cnt_r <= '0;
      free_run_r <= 1'b0;
    end else begin
      free_cnt_r <= free_cnt_nxt;
      free_run_r <= free_run_nxt;
    end
  end

  // Each event fires on the tick that wraps its tap, lowest rate on bit 0.
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
      assign irq_event[gi] = free_run_r && tick &&
                             ((free_cnt_r & IRQ_WRAP_MASK[gi]) == IRQ_WRAP_MASK[gi]);
    end
  endgenerate

  //----------------------------------------------------------------------------
  // Alarm patterns and output
  //----------------------------------------------------------------------------
  logic [7:0] gate;
  logic       carrier;
  logic       alarm_raw;
  logic       alarm_wave;
  logic       tone_r, tone_nxt;

  assign carrier = free_cnt_r[CARRIER_TAP];
  assign gate[0] = 1'b1;
  assign gate[1] = (free_cnt_r[11:10] == 2'h0);
  assign gate[2] = ~free_cnt_r[12];
  assign gate[3] = ~free_cnt_r[14];
  assign gate[4] = (free_cnt_r[13:11] == 3'h0);
  assign gate[5] = ~free_cnt_r[9];
  assign gate[6] = (free_cnt_r[14:13] == 2'h0) && ~free_cnt_r[10];
  assign gate[7] = ~free_cnt_r[14] && (free_cnt_r[11:10] == 2'h0);

  // Unlisted multi-bit pattern values merge their gates; software must not use them.
  assign alarm_raw  = carrier && |(pattern_r & gate);
  assign alarm_wave = alarm_raw ^ inv_r;

  always_comb begin
    tone_nxt = select_r ? mel_wave_r : alarm_wave;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tone_r <= 1'b0;
    end else begin
      tone_r <= tone_nxt;
    end
  end

  assign tone_out_pin = tone_r;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_route_melody: assert property (
    select_r && $stable(select_r) |-> tone_out_pin == $past(mel_wave_r))
    else $error("tone pin does not follow melody wave");

  a_div_split: assert property (
    wr_div_low |=> divisor[7:0] == $past(wdata))
    else $error("divisor low byte not taken");

  a_half_period: assert property (
    mel_run_r && tick && mel_cnt_r == mel_last && !wr_div_high |=>
      mel_wave_r != $past(mel_wave_r) && mel_cnt_r == 13'h0000)
    else $error("melody did not toggle at terminal count");

  a_stop_clear: assert property (
    wr_div_high && !wdata[HIGH_RUN] |=> ##1 mel_cnt_r == 13'h0000 && !mel_wave_r)
    else $error("melody counter not stopped and cleared");

  a_fc_clear: assert property (
    wr_control && wdata[CTRL_FC_HI:CTRL_FC_LO] == FC_CLEAR |=>
      free_cnt_r == '0 && !free_run_r)
    else $error("free-run counter not cleared");

  a_fc_read_zero: assert property (
    rd_en && addr == ADDR_CONTROL |=> !rdata[CTRL_FC_HI])
    else $error("upper control field bit read as one");

  a_pattern_off: assert property (
    pattern_r == 8'h00 |-> !alarm_raw)
    else $error("alarm active with no pattern");

  a_carrier_rate: assert property (
    alarm_raw |-> free_cnt_r[CARRIER_TAP])
    else $error("alarm high outside carrier phase");

  a_pattern_two: assert property (
    pattern_r == 8'h02 && free_cnt_r[11:10] != 2'h0 |-> !alarm_raw)
    else $error("pattern two burst too long");

  a_invert_out: assert property (
    !select_r && $stable(select_r) |-> tone_out_pin == $past(alarm_raw ^ inv_r))
    else $error("alarm inversion wrong at pin");

  a_one_hz_event: assert property (
    free_run_r && tick && free_cnt_r == 15'h7fff |=> status_r[0])
    else $error("1 Hz event lost");

  // The fastest event must come once every four ticks, not on every other tick.
  a_fast_event: assert property (
    irq_event[4] |-> free_cnt_r[1:0] == 2'h3)
    else $error("8192 Hz event at wrong count");

  a_irq_level: assert property (
    $rose(irq) |-> $past(|(irq_event & irq_en_r)) || $past(wr_irq_en))
    else $error("interrupt rose without cause");

  a_free_wrap: assert property (
    free_run_r && tick && free_cnt_r == 15'h7fff && !wr_control |=> free_cnt_r == '0)
    else $error("free-run counter did not wrap at 15 bits");

  c_melody_toggle: cover property (mel_run_r && select_r && $rose(tone_out_pin));
  c_alarm_two:     cover property (pattern_r == 8'h02 && $rose(alarm_raw));
  c_irq_raised:    cover property ($rose(irq));
  c_set_and_clear: cover property (wr_status && |irq_event);

endmodule // melody_alarm_tone_generator

// >>> test/tone_speaker.sv
// Loudspeaker model that listens to the tone pin and measures its waveform.
`timescale 1ns/1ps

module tone_speaker (
  input  wire logic sys_clk,
  input  wire logic tone_in,
  input  wire logic clr,
  output int        period,
  output int        high,
  output int        edges
);
  //----------------------------------------------------------------------------
  // Edge timing
  //----------------------------------------------------------------------------
  // The speaker only listens, so it never drives or releases the pin.
  logic last_r;
  int   since_r;

  always_ff @(posedge sys_clk) begin
    last_r  <= tone_in;
    since_r <= since_r + 1;
    if (tone_in === 1'b1 && last_r === 1'b0) begin
      period  <= since_r;
      since_r <= 1;
    end
    if (tone_in === 1'b0 && last_r === 1'b1) begin
      high <= since_r;
    end
    if (clr) begin
      edges <= 0;
    end else if (tone_in === 1'b1 && last_r === 1'b0) begin
      edges <= edges + 1;
    end
  end
endmodule // tone_speaker

// >>> test/melody_alarm_tone_generator_test.sv
// Self-checking testbench of the melody and alarm tone generator.
`timescale 1ns/1ps

module melody_alarm_tone_generator_test
  import tone_gen_pkg::*;
;
  //----------------------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------------------
  localparam int TIMEOUT = 80000;
  logic              sys_clk      = 1'b0;
  logic              reset_n      = 1'b0;
  logic              lowspeed_clk = 1'b0;
  logic [ADDR_W-1:0] addr         = 12'h000;
  logic [DATA_W-1:0] wdata        = 8'h00;
  logic              wr_en        = 1'b0;
  logic              rd_en        = 1'b0;
  logic              clr          = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              tone_out_pin;
  logic              irq;
  logic [31:0]       lfsr         = 32'hcdf72158;
  int                period;
  int                high;
  int                edges;
  int                bad_count    = 0;
  int                cmp_count    = 0;
  int                cyc          = 0;

  melody_alarm_tone_generator u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .lowspeed_clk(lowspeed_clk), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .tone_out_pin(tone_out_pin), .irq(irq)
  );

  tone_speaker u_speaker (
    .sys_clk(sys_clk), .tone_in(tone_out_pin), .clr(clr), .period(period),
    .high(high), .edges(edges)
  );

  //----------------------------------------------------------------------------
  // Clocks and helpers
  //----------------------------------------------------------------------------
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // One low-speed tick every 8 system cycles keeps the long counts affordable.
  initial begin
    forever begin
      repeat (4) @(posedge sys_clk);
      lowspeed_clk <= ~lowspeed_clk;
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT) begin
      bad_count++;
      complete_run();
    end
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  // System cycles in half a melody period: divisor plus two ticks of eight cycles.
  function automatic int half_cycles(input logic [11:0] nv);
    return (int'(nv) + 2) * 8;
  endfunction

  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp, input string msg);
    cmp_count++;
    if (got != exp) begin
      bad_count++;
      $display("Error at %0t: %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [7:0] exp, input string msg);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk8(rdata, exp, msg);
  endtask

  task automatic chk_pins(input logic [1:0] exp, input string msg);
    #1;
    chk8({6'h00, irq, tone_out_pin}, {6'h00, exp}, msg);
  endtask

  task automatic ticks(input int n);
    repeat (n * 8) @(posedge sys_clk);
  endtask

  task automatic pulse_clr();
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask

  task automatic melody(input logic [11:0] nv);
    wr(ADDR_CONTROL, 8'h01);
    wr(ADDR_DIV_LOW, nv[7:0]);
    wr(ADDR_DIV_HIGH, {4'h8, nv[11:8]});
    ticks(3 * (2 * int'(nv) + 4) + 8);
    chk_num(period, 2 * half_cycles(nv), "melody period");
    chk_num(high, half_cycles(nv), "melody half");
    wr(ADDR_DIV_HIGH, 8'h00);
    ticks(1);
    chk_pins(2'b00, "melody stop");
  endtask

  //----------------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------------
  initial begin
    logic [7:0] d;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      chk_rd(ADDR_PATTERN + 12'(i), REG_RESET, "reset value");
    end
    chk_pins(2'b00, "reset pins");
    wr(12'h336, 8'hff);
    chk_rd(12'h336, 8'h00, "unmapped");
    chk_rd(12'h32f, 8'h00, "unmapped");
    $display("test registers-reset done");

    for (int i = 0; i < 4; i++) begin
      d = rnd();
      wr(ADDR_PATTERN, d);
      chk_rd(ADDR_PATTERN, d, "pattern rw");
      wr(ADDR_DIV_LOW, d);
      chk_rd(ADDR_DIV_LOW, d, "divisor low");
      wr(ADDR_DIV_HIGH, d);
      chk_rd(ADDR_DIV_HIGH, d & 8'h8f, "divisor high");
      wr(ADDR_IRQ_ENABLE, d & 8'h1f);
      chk_rd(ADDR_IRQ_ENABLE, d & 8'h1f, "enable");
      d = {2'(i), d[5:0]};
      wr(ADDR_CONTROL, d);
      chk_rd(ADDR_CONTROL, {1'b0, d[6], d[5:0]}, "control field");
    end
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_DIV_HIGH, 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    wr(ADDR_IRQ_STATUS, 8'h1f);
    wr(ADDR_PATTERN, 8'h00);
    $display("test registers-random done");

    melody(12'h001);
    melody(12'h103);
    for (int i = 0; i < 2; i++) begin
      d = rnd();
      melody({7'h00, d[4:0]} + 12'h001);
    end
    $display("test melody done");

    // Only the two fastest events fit the run; the 64 Hz, 2 Hz and 1 Hz taps stay unseen.
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_IRQ_STATUS, 8'h1f);
    wr(ADDR_CONTROL, 8'hc0);
    ticks(100);
    wr(ADDR_CONTROL, 8'h00);
    chk_rd(ADDR_IRQ_STATUS, 8'h18, "event rates");
    chk_pins(2'b00, "irq masked");
    wr(ADDR_IRQ_ENABLE, 8'h08);
    chk_pins(2'b10, "irq raised");
    wr(ADDR_IRQ_ENABLE, 8'h07);
    chk_pins(2'b00, "irq gated");
    wr(ADDR_IRQ_STATUS, 8'h08);
    chk_rd(ADDR_IRQ_STATUS, 8'h10, "status clear");
    wr(ADDR_IRQ_ENABLE, 8'h10);
    chk_pins(2'b10, "irq fast");
    wr(ADDR_IRQ_STATUS, 8'h10);
    chk_pins(2'b00, "irq cleared");
    wr(ADDR_IRQ_ENABLE, 8'h00);
    $display("test interrupts done");

    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_DIV_HIGH, 8'h81);
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_PATTERN, 8'h00);
    wr(ADDR_CONTROL, 8'h40);
    pulse_clr();
    ticks(64);
    chk_num(edges, 0, "fixed low");
    chk_pins(2'b00, "fixed low pin");
    wr(ADDR_CONTROL, 8'h60);
    ticks(2);
    chk_pins(2'b01, "inverted low");
    wr(ADDR_PATTERN, 8'h01);
    ticks(32);
    chk_num(period, 64, "carrier period");
    chk_num(high, 32, "carrier half");
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_DIV_HIGH, 8'h00);
    wr(ADDR_PATTERN, 8'h02);
    wr(ADDR_CONTROL, 8'h40);
    pulse_clr();
    ticks(1032);
    chk_num(edges, 128, "burst carrier");
    pulse_clr();
    ticks(2000);
    chk_num(edges, 0, "burst gap");
    $display("test alarm done");
    complete_run();
  end
endmodule // melody_alarm_tone_generator_test
